// ===== shared/urf_pkg.sv
/*
 * Shared constants for the channel A receive mode block: register map,
 * field positions, command codes, reset values and fill thresholds.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package urf_pkg;

    // Data path widths
    localparam int DATA_W  = 8;
    localparam int STAT_W  = 3;
    localparam int WORD_W  = DATA_W + STAT_W;
    localparam int CNT_W   = 5;
    localparam int IRQ_W   = 3;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_COMMAND   = 8'h08;
    localparam logic [7:0] OFF_RXDATA    = 8'h0C;
    localparam logic [7:0] OFF_MODE_ZERO = 8'h10;
    localparam logic [7:0] OFF_OUT_PORT  = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h1C;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h20;

    // Field positions in the mode registers
    localparam int MODE1_FLOW_BIT  = 7;
    localparam int MODE1_FILL_BIT  = 6;
    localparam int MODE1_ACC_BIT   = 5;
    localparam int MODE0_FILL_BIT  = 6;
    localparam int MODE0_DEPTH_BIT = 3;

    // Status register bit positions
    localparam int STAT_HAS_DATA = 0;
    localparam int STAT_FULL     = 1;
    localparam int STAT_FILL     = 2;
    localparam int STAT_OVERRUN  = 4;
    localparam int STAT_ERR_LO   = 5;

    // Interrupt event bits
    localparam int IRQ_FILL = 0;
    localparam int IRQ_OVR  = 1;
    localparam int IRQ_ERR  = 2;

    // Command codes, low nibble of the command register
    localparam logic [3:0] CMD_SET_PTR   = 4'h1;
    localparam logic [3:0] CMD_RX_RESET  = 4'h2;
    localparam logic [3:0] CMD_ERR_RESET = 4'h4;

    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;

    // Queue depths and receive fill thresholds
    localparam logic [CNT_W-1:0] DEPTH_SHALLOW = 5'h08;
    localparam logic [CNT_W-1:0] DEPTH_DEEP    = 5'h10;
    localparam logic [CNT_W-1:0] FILL_ANY      = 5'h01;
    localparam logic [CNT_W-1:0] FILL8_LOW     = 5'h03;
    localparam logic [CNT_W-1:0] FILL8_HIGH    = 5'h06;
    localparam logic [CNT_W-1:0] FILL16_LOW    = 5'h08;
    localparam logic [CNT_W-1:0] FILL16_HIGH   = 5'h0C;

    typedef enum logic {PTR_ONE, PTR_TWO} urf_ptr_t;

    // Fill level that raises the receive interrupt condition
    function automatic logic [CNT_W-1:0] urf_fill_level(input logic [1:0] code, input logic deep);
        case (code)
            2'b00: urf_fill_level = FILL_ANY;
            2'b01: urf_fill_level = deep ? FILL16_LOW : FILL8_LOW;
            2'b10: urf_fill_level = deep ? FILL16_HIGH : FILL8_HIGH;
            default: urf_fill_level = deep ? DEPTH_DEEP : DEPTH_SHALLOW;
        endcase
    endfunction

endpackage

// ===== shared/urf_fifo_if.sv
/*
 * Connection between the receive control logic and its character store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface urf_fifo_if #(
    parameter int W  = 11,
    parameter int CW = 5
);
    logic          push;
    logic          pop;
    logic          flush;
    logic [W-1:0]  push_word;
    logic [W-1:0]  head_word;
    logic [CW-1:0] count;

    modport ctrl  (output push, output pop, output flush, output push_word, input head_word, input count);
    modport store (input push, input pop, input flush, input push_word, output head_word, output count);
endinterface

// ===== rtl/urf_rx_fifo.sv
/*
 * Receive character store: a circular buffer of data plus status words.
 * Assumes the controller never pops when empty; a push when full is ignored.
 */
`timescale 1ns/1ps
module urf_rx_fifo #(
    parameter int DEPTH = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    urf_fifo_if.store fq
);
    localparam int AW = $clog2(DEPTH);

    logic [$bits(fq.push_word)-1:0] mem [DEPTH];
    logic [AW-1:0]                  wr_ptr_ff;
    logic [AW-1:0]                  rd_ptr_ff;
    logic [AW:0]                    count_ff;
    wire                            do_push = fq.push & (count_ff != (AW+1)'(DEPTH));
    wire                            do_pop  = fq.pop & (count_ff != '0);

    assign fq.head_word = mem[rd_ptr_ff];
    assign fq.count     = $bits(fq.count)'(count_ff);

    // Storage needs no reset; stale words are never shown as valid
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= fq.push_word;
        end
    end

    // Pointers and occupancy; flush beats push and pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (fq.flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= do_push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
            rd_ptr_ff <= do_pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
            count_ff  <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// ===== rtl/urf_rx_mode_top.sv
/*
 * Channel A receive mode block: mode register pointer, request-to-send
 * flow control, receive fill level, error status accumulation, APB slave
 * and interrupt. Assumes the receiver front end runs on pclk and reports
 * start bits and finished characters as one-cycle pulses.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
//
// Notes on behaviour
// - Reset or command 1 points at mode one
// - Access to mode one moves pointer to two
// - Block errors stay until error or receiver reset
// - Mode one bit 7 enables flow control
// - Start bit while full negates request-to-send
// - Full until next start: overrun, byte dropped
// - Port bit kept; reassert when space frees
// - Port bit 0 drives request-to-send
// - Mode one bit 6 is fill code low bit
// - Mode one bit 5 selects block accumulation
// - Character mode shows top entry status only
// - Block mode ORs status since error reset
// - Fill thresholds per code and depth
// - Mode zero bit 3 selects depth
module urf_rx_mode_top
    import urf_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rx_start,
    input  wire logic              rx_char_valid,
    input  wire logic [DATA_W-1:0] rx_char_data,
    input  wire logic              rx_char_framing,
    input  wire logic              rx_char_parity,
    input  wire logic              rx_char_break,
    output logic                   irq,
    output logic                   request_to_send_out_a_n
);
    urf_fifo_if #(.W(WORD_W), .CW(CNT_W)) fq ();

    urf_rx_fifo #(.DEPTH(DEPTH)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .fq      (fq)
    );

    urf_ptr_t          ptr_ff;
    logic [7:0]        mode_reg_one_a_ff;
    logic [7:0]        mode_reg_two_a_ff;
    logic [7:0]        mode_reg_zero_ff;
    logic [7:0]        output_port_bits_ff;
    logic [IRQ_W-1:0]  irq_stat_ff;
    logic [IRQ_W-1:0]  irq_en_ff;
    logic [STAT_W-1:0] acc_ff;
    logic              overrun_ff;
    logic              rts_neg_ff;
    logic              discard_ff;
    logic              hold_v_ff;
    logic [WORD_W-1:0] hold_ff;
    logic              pop_arm_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic              irq_ff;
    logic              rts_pin_ff;

    // Bus phases and address decode
    wire access    = psel & penable;
    wire capture   = access & ~pready_ff;
    wire fire      = access & pready_ff;
    wire wr        = fire & pwrite;
    wire hit_mode  = paddr == OFF_MODE;
    wire hit_stat  = paddr == OFF_STATUS;
    wire hit_cmd   = paddr == OFF_COMMAND;
    wire hit_rxd   = paddr == OFF_RXDATA;
    wire hit_mr0   = paddr == OFF_MODE_ZERO;
    wire hit_opr   = paddr == OFF_OUT_PORT;
    wire hit_ist   = paddr == OFF_IRQ_STAT;
    wire hit_icl   = paddr == OFF_IRQ_CLR;
    wire hit_ien   = paddr == OFF_IRQ_EN;
    wire mapped    = hit_mode | hit_stat | hit_cmd | hit_rxd | hit_mr0 | hit_opr | hit_ist | hit_icl | hit_ien;

    // Commands and mode register steering
    wire set_ptr   = wr & hit_cmd & (pwdata[3:0] == CMD_SET_PTR);
    wire err_rst   = wr & hit_cmd & (pwdata[3:0] == CMD_ERR_RESET);
    wire rx_rst    = wr & hit_cmd & (pwdata[3:0] == CMD_RX_RESET);
    wire mode_one  = hit_mode & (ptr_ff == PTR_ONE);
    wire flow_en   = mode_reg_one_a_ff[MODE1_FLOW_BIT];
    wire acc_sel   = mode_reg_one_a_ff[MODE1_ACC_BIT];
    wire [1:0] fill_code = {mode_reg_zero_ff[MODE0_FILL_BIT], mode_reg_one_a_ff[MODE1_FILL_BIT]};
    wire deep      = mode_reg_zero_ff[MODE0_DEPTH_BIT];

    // Queue occupancy against the selected depth
    wire [CNT_W-1:0] depth_now = deep ? DEPTH_SHALLOW << 1 : DEPTH_SHALLOW;
    wire empty     = fq.count == '0;
    wire full      = fq.count >= depth_now;
    wire fill_ok   = fq.count >= urf_fill_level(fill_code, deep);

    // Line side: one character held past the selected depth, then overrun on the next start
    wire ovr_ev    = rx_start & full & hold_v_ff;
    wire in_ok     = rx_char_valid & ~discard_ff & ~ovr_ev;
    wire [WORD_W-1:0] in_word = {rx_char_break, rx_char_framing, rx_char_parity, rx_char_data};
    wire push      = ~full & (hold_v_ff | in_ok);

    assign fq.push      = push & ~rx_rst;
    assign fq.push_word = hold_v_ff ? hold_ff : in_word;
    assign fq.flush     = rx_rst;
    assign fq.pop       = fire & ~pwrite & hit_rxd & pop_arm_ff;

    // Error status of the top entry and its accumulation
    wire [STAT_W-1:0] head_stat = empty ? '0 : fq.head_word[WORD_W-1:DATA_W];
    wire [STAT_W-1:0] err_view  = acc_sel ? acc_ff : head_stat;
    wire [STAT_W-1:0] nxt_acc   = ((err_rst | rx_rst) ? '0 : acc_ff) | head_stat;

    // Status register image
    wire [7:0] status_reg = {err_view, overrun_ff, 1'b0, fill_ok, full, ~empty};

    // Interrupt events; a set in the clearing cycle survives
    wire [IRQ_W-1:0] irq_ev  = {|head_stat, ovr_ev, fill_ok};
    wire [IRQ_W-1:0] irq_clr = (wr & hit_icl) ? pwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

    // Read data selection
    wire [7:0] rd_byte =
        hit_mode ? (mode_one ? mode_reg_one_a_ff : mode_reg_two_a_ff) :
        hit_stat ? status_reg :
        hit_rxd  ? (empty ? 8'h00 : fq.head_word[DATA_W-1:0]) :
        hit_mr0  ? mode_reg_zero_ff :
        hit_opr  ? output_port_bits_ff :
        hit_ist  ? {5'h00, irq_stat_ff} :
        hit_ien  ? {5'h00, irq_en_ff} : 8'h00;

    // Pointer: reset or command goes to one, any access to one moves on
    urf_ptr_t nxt_ptr;
    assign nxt_ptr = set_ptr ? PTR_ONE :
                     (fire & mode_one) ? PTR_TWO : ptr_ff;

    // Flow control: negate on a start bit into a full queue, release on space
    wire nxt_rts_neg = flow_en & (rx_start & full | rts_neg_ff & full) & ~rx_rst;

    // APB answer: one wait state, then ready with data or error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pop_arm_ff <= 1'b0;
        end else begin
            pready_ff  <= capture;
            pslverr_ff <= capture & ~mapped;
            prdata_ff  <= capture & ~pwrite ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pop_arm_ff <= capture & hit_rxd & ~empty;
        end
    end

    // Software-visible registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff              <= PTR_ONE;
            mode_reg_one_a_ff   <= MODE_RST;
            mode_reg_two_a_ff   <= MODE_RST;
            mode_reg_zero_ff    <= MODE_RST;
            output_port_bits_ff <= PORT_RST;
            irq_en_ff           <= '0;
        end else begin
            ptr_ff <= nxt_ptr;
            if (wr & mode_one) begin
                mode_reg_one_a_ff <= pwdata[7:0];
            end
            if (wr & hit_mode & ~mode_one) begin
                mode_reg_two_a_ff <= pwdata[7:0];
            end
            if (wr & hit_mr0) begin
                mode_reg_zero_ff <= pwdata[7:0];
            end
            if (wr & hit_opr) begin
                output_port_bits_ff <= pwdata[7:0];
            end
            if (wr & hit_ien) begin
                irq_en_ff <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Receive side state: held character, discard, overrun, errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_v_ff  <= 1'b0;
            hold_ff    <= '0;
            discard_ff <= 1'b0;
            overrun_ff <= 1'b0;
            acc_ff     <= '0;
            rts_neg_ff <= 1'b0;
        end else begin
            acc_ff     <= nxt_acc;
            rts_neg_ff <= nxt_rts_neg;
            overrun_ff <= ovr_ev | (overrun_ff & ~err_rst & ~rx_rst);
            discard_ff <= ~rx_rst & (ovr_ev | (discard_ff & ~rx_char_valid));
            if (rx_rst) begin
                hold_v_ff <= 1'b0;
            end else if (hold_v_ff & push) begin
                hold_v_ff <= in_ok;
                hold_ff   <= in_word;
            end else if (~hold_v_ff & in_ok & ~push) begin
                hold_v_ff <= 1'b1;
                hold_ff   <= in_word;
            end
        end
    end

    // Pin and interrupt outputs; pin is high (negated) when the port bit is clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
            rts_pin_ff  <= 1'b1;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(irq_stat_ff & irq_en_ff);
            rts_pin_ff  <= ~output_port_bits_ff[0] | rts_neg_ff;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq     = irq_ff;
    assign request_to_send_out_a_n = rts_pin_ff;

    // Checks on the behaviour above
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_set_ptr_cmd;
        set_ptr;
    endsequence

    sequence s_start_full;
        flow_en & rx_start & full & ~rx_rst;
    endsequence

    sequence s_negated_pin;
        rts_neg_ff ##1 request_to_send_out_a_n;
    endsequence

    ptr_reset_a: assert property (s_set_ptr_cmd |=> ptr_ff == PTR_ONE)
        else $error("pointer not back at mode one");

    ptr_advance_a: assert property (fire & mode_one & ~set_ptr |=> ptr_ff == PTR_TWO)
        else $error("pointer did not move to mode two");

    block_hold_a: assert property (~err_rst & ~rx_rst |=> (acc_ff & $past(acc_ff)) == $past(acc_ff))
        else $error("accumulated error lost without reset");

    flow_off_a: assert property (~flow_en |=> ~rts_neg_ff)
        else $error("flow negation while disabled");

    rts_negate_a: assert property (s_start_full |=> s_negated_pin)
        else $error("request-to-send not negated on full start");

    overrun_flag_a: assert property (ovr_ev & ~rx_rst |=> overrun_ff & discard_ff)
        else $error("overrun not flagged");

    rts_release_a: assert property (rts_neg_ff & ~full & output_port_bits_ff[0] |=> ##1 ~request_to_send_out_a_n)
        else $error("request-to-send not reasserted");

    port_bit_a: assert property (~output_port_bits_ff[0] |=> request_to_send_out_a_n)
        else $error("pin low while port bit clear");

    char_mode_a: assert property (~acc_sel & ~empty |-> status_reg[7:5] == fq.head_word[WORD_W-1:DATA_W])
        else $error("character status not from top entry");

    fill_level_a: assert property (fill_code == 2'b11 |-> fill_ok == (fq.count >= depth_now))
        else $error("fill level mismatch");

    depth_full_a: assert property (~deep & fq.count == 5'h08 |-> full)
        else $error("shallow depth not full at eight");
endmodule

// ===== tb/urf_remote_tx.sv
/*
 * Remote serial sender model: one character per go pulse, start bit first.
 * Assumes the bench pulses go for one cycle while busy is low.
 */
`timescale 1ns/1ps
module urf_remote_tx (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       ignore_cts,
    input  wire logic [7:0] d_in,
    input  wire logic [2:0] e_in,
    input  wire logic       clear_to_send_in_n,
    output logic            busy,
    output logic            rx_start,
    output logic            rx_char_valid,
    output logic [7:0]      rx_char_data,
    output logic [2:0]      rx_char_err
);
    logic [10:0] word_ff;
    logic [2:0]  cnt_ff;

    // Start bit, a few bit times, then the finished character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy          <= 1'b0;
            rx_start      <= 1'b0;
            rx_char_valid <= 1'b0;
            rx_char_data  <= 8'h00;
            rx_char_err   <= 3'h0;
            word_ff       <= 11'h000;
            cnt_ff        <= 3'h0;
        end else begin
            rx_start      <= 1'b0;
            rx_char_valid <= 1'b0;
            rx_char_data  <= ~rx_char_data; // Toggle so a stale value never passes
            rx_char_err   <= ~rx_char_err;
            if (go && !busy) begin
                busy    <= 1'b1;
                word_ff <= {e_in, d_in};
                cnt_ff  <= 3'h0;
            end else if (busy && cnt_ff == 3'h0) begin
                if (ignore_cts || !clear_to_send_in_n) begin
                    rx_start <= 1'b1;
                    cnt_ff   <= 3'h1;
                end
            end else if (busy && cnt_ff != 3'h5) begin
                cnt_ff <= cnt_ff + 3'h1;
            end else if (busy) begin
                rx_char_valid               <= 1'b1;
                {rx_char_err, rx_char_data} <= word_ff;
                busy                        <= 1'b0;
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the receive mode block: APB master tasks,
 * one task per scenario. Assumes the sender model on the line side.
 */
`timescale 1ns/1ps
module tb_top
    import urf_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rts_n;
    logic        go, ign, busy, rx_start, rx_valid, err;
    logic [7:0]  paddr, d_in, rx_data;
    logic [2:0]  e_in, rx_err;
    logic [31:0] pwdata, prdata, r;
    int          miscompares, compares;
    int          thr [8] = '{1, 3, 6, 8, 1, 8, 12, 16};

    // Free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    urf_rx_mode_top #(.DEPTH(16)) urf_rx_mode_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_start(rx_start), .rx_char_valid(rx_valid),
        .rx_char_data(rx_data), .rx_char_framing(rx_err[0]), .rx_char_parity(rx_err[1]),
        .rx_char_break(rx_err[2]), .irq(irq), .request_to_send_out_a_n(rts_n));
    urf_remote_tx urf_remote_tx_i (.pclk(pclk), .presetn(presetn), .go(go), .ignore_cts(ign),
        .d_in(d_in), .e_in(e_in), .clear_to_send_in_n(rts_n), .busy(busy), .rx_start(rx_start),
        .rx_char_valid(rx_valid), .rx_char_data(rx_data), .rx_char_err(rx_err));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic stall(input string w);
        miscompares++;
        $display("MISMATCH at %0t: timeout in %s", $time, w);
        wrap_up();
    endtask

    // One transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) stall("apb");
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string w);
        apb(1'b0, a, 32'h00000000);
        chk(r & m, e, w);
    endtask

    task automatic set_m1(input logic [7:0] v);
        wr(OFF_COMMAND, {4'h0, CMD_SET_PTR});
        wr(OFF_MODE, v);
    endtask

    // Hand a character to the sender and wait until it has landed
    task automatic send(input logic [7:0] d, input logic [2:0] e, input logic i);
        int n;
        @(posedge pclk);
        go   <= 1'b1;
        d_in <= d;
        e_in <= e;
        ign  <= i;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) stall("sender");
        repeat (2) @(posedge pclk);
    endtask

    // Pin levels settle a couple of edges after their cause
    task automatic wait_lvl(input logic use_irq, input logic e, input string w);
        int n;
        n = 0;
        while ((use_irq ? irq : rts_n) !== e && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, use_irq ? irq : rts_n}, {31'h0, e}, w);
    endtask

    task automatic t_reset();
        chk({30'h0, irq, rts_n}, 32'h00000001, "pins after reset");
        rdc(OFF_OUT_PORT, {24'h0, PORT_RST}, 32'hFFFFFFFF, "port reset");
        rdc(OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF, "irq status reset");
    endtask

    task automatic t_pointer();
        wr(OFF_MODE, 8'hA5);
        wr(OFF_MODE, 8'h3C);
        rdc(OFF_MODE, 32'h3C, 32'hFFFFFFFF, "mode two");
        wr(OFF_COMMAND, {4'h0, CMD_SET_PTR});
        rdc(OFF_MODE, 32'hA5, 32'hFFFFFFFF, "mode one");
        rdc(OFF_MODE, 32'h3C, 32'hFFFFFFFF, "after mode one");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
    endtask

    task automatic t_flow();
        wr(OFF_COMMAND, {4'h0, CMD_RX_RESET});
        wr(OFF_MODE_ZERO, 8'h00);
        set_m1(8'h80);
        wr(OFF_OUT_PORT, 8'h01);
        wait_lvl(1'b0, 1'b0, "rts on");
        for (int i = 0; i < 8; i++) send(8'h40 + 8'(i), 3'h0, 1'b0);
        rdc(OFF_STATUS, 32'h02, 32'h02, "full at 8");
        send(8'h48, 3'h0, 1'b0);
        wait_lvl(1'b0, 1'b1, "rts negated");
        rdc(OFF_RXDATA, 32'h40, 32'hFF, "pop 0");
        rdc(OFF_RXDATA, 32'h41, 32'hFF, "pop 1");
        wait_lvl(1'b0, 1'b0, "rts back");
        rdc(OFF_OUT_PORT, 32'h01, 32'hFF, "port kept");
        send(8'h49, 3'h0, 1'b0);
        send(8'h4A, 3'h0, 1'b1);
        send(8'h4B, 3'h0, 1'b1);
        rdc(OFF_STATUS, 32'h10, 32'h10, "overrun");
        for (int i = 0; i < 9; i++) rdc(OFF_RXDATA, 32'h42 + i, 32'hFF, "drain");
        rdc(OFF_STATUS, 32'h0, 32'h01, "empty");
    endtask

    task automatic t_irq();
        wr(OFF_IRQ_EN, 8'h02);
        wait_lvl(1'b1, 1'b1, "irq raised");
        wr(OFF_IRQ_EN, 8'h00);
        wait_lvl(1'b1, 1'b0, "irq masked");
        wr(OFF_COMMAND, {4'h0, CMD_ERR_RESET});
        wr(OFF_IRQ_CLR, 8'h02);
        rdc(OFF_IRQ_STAT, 32'h0, 32'h02, "irq cleared");
        rdc(OFF_IRQ_CLR, 32'h0, 32'hFFFFFFFF, "clear reads zero");
    endtask

    task automatic t_err();
        wr(OFF_COMMAND, {4'h0, CMD_RX_RESET});
        set_m1(8'h00);
        send(8'h11, 3'h2, 1'b0);
        send(8'h12, 3'h0, 1'b0);
        rdc(OFF_STATUS, 32'h20, 32'hE0, "top has parity");
        rdc(OFF_RXDATA, 32'h11, 32'hFF, "pop bad");
        rdc(OFF_STATUS, 32'h00, 32'hE0, "top clean");
        rdc(OFF_RXDATA, 32'h12, 32'hFF, "pop clean");
        set_m1(8'h20);
        send(8'h13, 3'h1, 1'b0);
        send(8'h14, 3'h4, 1'b0);
        for (int i = 0; i < 2; i++) rdc(OFF_RXDATA, 32'h13 + i, 32'hFF, "pop block");
        rdc(OFF_STATUS, 32'hE0, 32'hE0, "block or");
        wr(OFF_COMMAND, {4'h0, CMD_ERR_RESET});
        rdc(OFF_STATUS, 32'h00, 32'hE0, "error reset");
        send(8'h15, 3'h1, 1'b0);
        rdc(OFF_RXDATA, 32'h15, 32'hFF, "pop framing");
        rdc(OFF_STATUS, 32'h40, 32'hE0, "held while empty");
        wr(OFF_COMMAND, {4'h0, CMD_RX_RESET});
        rdc(OFF_STATUS, 32'h00, 32'hE0, "receiver reset");
    endtask

    // Every fill code at both depths, one below and at the level
    task automatic t_fill();
        for (int k = 0; k < 8; k++) begin
            wr(OFF_COMMAND, {4'h0, CMD_RX_RESET});
            wr(OFF_MODE_ZERO, {1'b0, k[1], 2'b00, k[2], 3'b000});
            set_m1({1'b0, k[0], 6'h00});
            for (int i = 1; i < thr[k]; i++) send(8'h60, 3'h0, 1'b0);
            rdc(OFF_STATUS, 32'h0, 32'h04, "below level");
            send(8'h61, 3'h0, 1'b0);
            rdc(OFF_STATUS, (k % 4 == 3) ? 32'h06 : 32'h04, 32'h06, "at level");
            if (k == 3) begin
                send(8'h62, 3'h0, 1'b0);
                chk({31'h0, rts_n}, 32'h0, "no flow control");
            end
        end
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, go, ign} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        d_in = 8'h00;
        e_in = 3'h0;
        miscompares = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pointer();
        t_flow();
        t_irq();
        t_err();
        t_fill();
        wrap_up();
    end
endmodule
